// ===== hdl/alu_incdec_divide_step.sv
// ALU slice executing increment, decrement and divide primitives
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.svh"

module alu_incdec_divide_step #(
   parameter int ADDR_W = 6
) (
   input  wire logic               aclk,
   input  wire logic               aresetn,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               instr_valid,
   input  wire logic [23:0]        instr,
   input  wire logic               cond_true,
   input  wire logic [15:0]        mac_result_hi,
   input  wire logic [15:0]        mac_result_mid,
   input  wire logic [15:0]        mac_result_lo,
   input  wire logic [15:0]        shift_result_hi,
   input  wire logic [15:0]        shift_result_lo,
   output logic                    instr_done
);
   if (ADDR_W < 6) begin : g_addr_check
      $error("ADDR_W must be at least 6");
   end

   // ==================================================
   // Register state
   logic [7:0]  arithmetic_status_r, arithmetic_status_nxt;
   logic [15:0] y_operand_0_r, y_operand_0_nxt;
   logic [15:0] y_operand_1_r, y_operand_1_nxt;
   logic [15:0] x_operand_0_r, x_operand_0_nxt;
   logic [15:0] x_operand_1_r, x_operand_1_nxt;
   logic [15:0] result_reg_r, result_reg_nxt;
   logic [15:0] feedback_reg_r, feedback_reg_nxt;
   logic        done_r, done_nxt;

   // ==================================================
   // Instruction decode
   logic [4:0]  function_code;
   logic        dest_fb;
   logic [1:0]  ysel;
   logic [2:0]  xsel;
   logic        is_t9, is_inc, is_dec, is_div_quotient_step, is_div_sign_step, exec_incdec;
   logic [15:0] yop, xop;

   assign function_code = instr[17:13];
   assign dest_fb       = instr[18];
   assign ysel          = instr[12:11];
   assign xsel          = instr[10:8];
   assign is_t9   = instr_valid && instr[23:19] == `OPC_TYPE9 && instr[7:4] == 4'h0;
   assign is_inc  = is_t9 && function_code == `FC_INC;
   assign is_dec  = is_t9 && function_code == `FC_DEC;
   assign is_div_quotient_step = instr_valid && instr[23:11] == `OPC_DIV_QUOTIENT_STEP && instr[7:0] == 8'h00;
   assign is_div_sign_step = instr_valid && instr[23:13] == `OPC_DIV_SIGN_STEP && instr[7:0] == 8'h00;
   // Decoder reports an absent condition as true, so those run every time
   assign exec_incdec = (is_inc || is_dec) && cond_true;

   always_comb begin
      case (ysel)
         2'h0: yop = y_operand_0_r;
         2'h1: yop = y_operand_1_r;
         2'h2: yop = feedback_reg_r;
         default: yop = `WORD_RESET;
      endcase
      // Quotient step always works on the running remainder in feedback
      if (is_div_quotient_step) yop = feedback_reg_r;
      case (xsel)
         3'h0: xop = x_operand_0_r;
         3'h1: xop = x_operand_1_r;
         3'h2: xop = result_reg_r;
         3'h3: xop = mac_result_hi;
         3'h4: xop = mac_result_mid;
         3'h5: xop = mac_result_lo;
         3'h6: xop = shift_result_hi;
         default: xop = shift_result_lo;
      endcase
   end

   alu_pkg::alu_res_s res;
   logic [15:0] rem_shift;
   // Remainder shifted left taking the next numerator bit from y_operand_0
   assign rem_shift = {yop[14:0], y_operand_0_r[15]};

   alu_step #(.WIDTH(16)) u_step (
      .is_dec  (is_dec),
      .is_div_sign_step (is_div_sign_step),
      .is_div_quotient_step (is_div_quotient_step),
      .yop     (is_div_quotient_step ? rem_shift : yop),
      .xop     (xop),
      .q_in    (arithmetic_status_r[`ST_QUOT]),
      .res     (res)
   );

   // ==================================================
   // AXI4-Lite slave: single outstanding write and read
   logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0]  wstrb_r, wstrb_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic        wr_fire, wr_ok;
   logic [15:0] wval;

   assign s_axi_awready = !aw_got_r && !bvalid_r;
   assign s_axi_wready  = !w_got_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign instr_done    = done_r;
   assign wr_fire = aw_got_r && w_got_r;
   assign wr_ok   = awaddr_r[1:0] == 2'h0 && awaddr_r <= ADDR_W'(`ADDR_FEEDBACK);
   // Only the low lanes carry the 16-bit registers
   assign wval = {wstrb_r[1] ? wdata_r[15:8] : 8'h00, wstrb_r[0] ? wdata_r[7:0] : 8'h00};

   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt  = w_got_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt  = wdata_r;
      wstrb_nxt  = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt  = bresp_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt  = rdata_r;
      rresp_nxt  = rresp_r;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_got_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (wr_fire) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = wr_ok ? 2'h0 : 2'h2;
      end
      if (bvalid_r && s_axi_bready) bvalid_nxt = 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = 2'h0;
         case (s_axi_araddr)
            ADDR_W'(`ADDR_STATUS):   rdata_nxt = {24'h000000, arithmetic_status_r};
            ADDR_W'(`ADDR_Y0):       rdata_nxt = {16'h0000, y_operand_0_r};
            ADDR_W'(`ADDR_Y1):       rdata_nxt = {16'h0000, y_operand_1_r};
            ADDR_W'(`ADDR_X0):       rdata_nxt = {16'h0000, x_operand_0_r};
            ADDR_W'(`ADDR_X1):       rdata_nxt = {16'h0000, x_operand_1_r};
            ADDR_W'(`ADDR_RESULT):   rdata_nxt = {16'h0000, result_reg_r};
            ADDR_W'(`ADDR_FEEDBACK): rdata_nxt = {16'h0000, feedback_reg_r};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = 2'h2;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // ==================================================
   // Datapath next state; instruction wins over a same-cycle bus write
   always_comb begin
      arithmetic_status_nxt = arithmetic_status_r;
      y_operand_0_nxt = y_operand_0_r;
      y_operand_1_nxt = y_operand_1_r;
      x_operand_0_nxt = x_operand_0_r;
      x_operand_1_nxt = x_operand_1_r;
      result_reg_nxt  = result_reg_r;
      feedback_reg_nxt = feedback_reg_r;
      // Each primitive completes in one cycle, so 16 issues give 16 quotient bits
      done_nxt = exec_incdec || is_div_quotient_step || is_div_sign_step;
      if (wr_fire && wr_ok) begin
         case (awaddr_r[5:0])
            6'(`ADDR_STATUS):   arithmetic_status_nxt = wval[7:0];
            6'(`ADDR_Y0):       y_operand_0_nxt = wval;
            6'(`ADDR_Y1):       y_operand_1_nxt = wval;
            6'(`ADDR_X0):       x_operand_0_nxt = wval;
            6'(`ADDR_X1):       x_operand_1_nxt = wval;
            6'(`ADDR_RESULT):   result_reg_nxt = wval;
            default:            feedback_reg_nxt = wval;
         endcase
      end
      if (exec_incdec) begin
         if (dest_fb) feedback_reg_nxt = res.value;
         else result_reg_nxt = res.value;
         arithmetic_status_nxt[`ST_ZERO]  = res.zero;
         arithmetic_status_nxt[`ST_NEG]   = res.neg;
         arithmetic_status_nxt[`ST_OVF]   = res.ovf;
         arithmetic_status_nxt[`ST_CARRY] = res.carry;
      end
      if (is_div_sign_step || is_div_quotient_step) begin
         // Remainder stays raw; correcting it is left to software
         feedback_reg_nxt = res.value;
         if (is_div_sign_step) begin
            // Sign step only shifts the numerator up by one
            feedback_reg_nxt = {yop[14:0], y_operand_0_r[15]};
         end
         y_operand_0_nxt = {y_operand_0_r[14:0], ~res.quot ^ is_div_sign_step};
         if (is_div_sign_step) y_operand_0_nxt = {y_operand_0_r[14:0], res.quot};
         arithmetic_status_nxt[`ST_QUOT]  = res.quot;
         arithmetic_status_nxt[`ST_ZERO]  = res.zero;
         arithmetic_status_nxt[`ST_NEG]   = res.neg;
         arithmetic_status_nxt[`ST_OVF]   = res.ovf;
         arithmetic_status_nxt[`ST_CARRY] = res.carry;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arithmetic_status_r <= `STATUS_RESET;
         y_operand_0_r  <= `WORD_RESET;
         y_operand_1_r  <= `WORD_RESET;
         x_operand_0_r  <= `WORD_RESET;
         x_operand_1_r  <= `WORD_RESET;
         result_reg_r   <= `WORD_RESET;
         feedback_reg_r <= `WORD_RESET;
         done_r   <= 1'b0;
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r  <= 2'h0;
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h00000000;
         rresp_r  <= 2'h0;
      end else begin
         arithmetic_status_r <= arithmetic_status_nxt;
         y_operand_0_r  <= y_operand_0_nxt;
         y_operand_1_r  <= y_operand_1_nxt;
         x_operand_0_r  <= x_operand_0_nxt;
         x_operand_1_r  <= x_operand_1_nxt;
         result_reg_r   <= result_reg_nxt;
         feedback_reg_r <= feedback_reg_nxt;
         done_r   <= done_nxt;
         aw_got_r <= aw_got_nxt;
         w_got_r  <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r  <= wdata_nxt;
         wstrb_r  <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r  <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r  <= rdata_nxt;
         rresp_r  <= rresp_nxt;
      end
   end

   // ==================================================
   // Assertions
   inc_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_incdec && is_inc && !dest_fb |=> result_reg_r == $past(yop) + 16'h0001)
      else $error("increment result wrong");
   dec_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_incdec && is_dec && dest_fb |=> feedback_reg_r == $past(yop) - 16'h0001)
      else $error("decrement result wrong");
   false_cond_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (is_inc || is_dec) && !cond_true && !wr_fire |=> $stable(result_reg_r) && $stable(feedback_reg_r))
      else $error("false condition changed a destination");
   zero_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_incdec |=> arithmetic_status_r[`ST_ZERO] == ($past(res.value) == 16'h0000))
      else $error("zero flag wrong");
   neg_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_incdec |=> arithmetic_status_r[`ST_NEG] == $past(res.value[15]))
      else $error("negative flag wrong");
   keep_flags_a: assert property (@(posedge aclk) disable iff (!aresetn)
      exec_incdec |=> arithmetic_status_r[7:4] == $past(arithmetic_status_r[7:4]))
      else $error("inc/dec touched upper flags");
   quot_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
      is_div_sign_step || is_div_quotient_step |=> arithmetic_status_r[`ST_QUOT] == $past(res.quot))
      else $error("quotient flag not written");
   div_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
      is_div_sign_step || is_div_quotient_step |=> {arithmetic_status_r[7:6], arithmetic_status_r[4]}
         == {$past(arithmetic_status_r[7:6]), $past(arithmetic_status_r[4])})
      else $error("divide touched kept flags");
   quot_shift_a: assert property (@(posedge aclk) disable iff (!aresetn)
      is_div_quotient_step |=> y_operand_0_r[15:1] == $past(y_operand_0_r[14:0]))
      else $error("quotient register not shifted");
   resp_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> bvalid_r)
      else $error("write response missing");
   inc_cov: cover property (@(posedge aclk) disable iff (!aresetn) exec_incdec && is_inc);
   dec_cov: cover property (@(posedge aclk) disable iff (!aresetn) exec_incdec && is_dec);
   div_sign_step_cov: cover property (@(posedge aclk) disable iff (!aresetn) is_div_sign_step ##1 is_div_quotient_step);
   div_quotient_step_cov: cover property (@(posedge aclk) disable iff (!aresetn) is_div_quotient_step [*8]);
endmodule : alu_incdec_divide_step
`default_nettype wire

// ===== hdl/alu_defs.svh
// Constants for the increment, decrement and divide-step ALU slice
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// ==================================================
// Instruction fields
`define OPC_TYPE9        5'h04
`define FC_INC           5'h11
`define FC_DEC           5'h18
`define OPC_DIV_QUOTIENT_STEP         13'h00E2
`define OPC_DIV_SIGN_STEP         11'h030
// ==================================================
// Status bit positions
`define ST_ZERO          0
`define ST_NEG           1
`define ST_OVF           2
`define ST_CARRY         3
`define ST_SIGN          4
`define ST_QUOT          5
`define ST_MOVF          6
`define ST_SSIGN         7
// ==================================================
// Register map (byte addresses)
`define ADDR_STATUS      4'h0
`define ADDR_Y0          4'h4
`define ADDR_Y1          4'h8
`define ADDR_X0          4'hC
`define ADDR_X1          5'h10
`define ADDR_RESULT      5'h14
`define ADDR_FEEDBACK    5'h18
`define ADDR_INSTR       5'h1C
`define ADDR_COND        6'h20
`define STATUS_RESET     8'h00
`define WORD_RESET       16'h0000
`define ONE16            16'h0001

`endif

// ===== hdl/alu_pkg.sv
// Types shared by the ALU slice files
package alu_pkg;
   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_INC  = 2'h1,
      OP_DEC  = 2'h3,
      OP_DIV  = 2'h2
   } alu_op_e;

   typedef struct packed {
      logic [15:0] value;
      logic        zero;
      logic        neg;
      logic        ovf;
      logic        carry;
      logic        quot;
   } alu_res_s;
endpackage : alu_pkg

// ===== hdl/alu_step.sv
// Combinational arithmetic core: increment, decrement and divide steps
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.svh"

module alu_step #(
   parameter int WIDTH = 16
) (
   input  wire logic                  is_dec,
   input  wire logic                  is_div_sign_step,
   input  wire logic                  is_div_quotient_step,
   input  wire logic [WIDTH-1:0]      yop,
   input  wire logic [WIDTH-1:0]      xop,
   input  wire logic                  q_in,
   output alu_pkg::alu_res_s          res
);
   if (WIDTH != 16) begin : g_width_check
      $error("alu_step serves 16-bit operands only");
   end

   logic [WIDTH:0]   sum;
   logic [WIDTH-1:0] b;
   logic             cin;
   logic             q_new;

   always_comb begin
      sum = '0;
      b   = '0;
      cin = 1'b0;
      q_new = q_in;
      if (is_div_sign_step) begin
         // Quotient sign is the xor of both operand signs
         q_new = yop[WIDTH-1] ^ xop[WIDTH-1];
         sum   = {1'b0, yop};
      end else if (is_div_quotient_step) begin
         // Non-restoring: subtract when last bit was 0, add when 1
         b     = q_in ? xop : ~xop;
         cin   = ~q_in;
         sum   = {1'b0, yop} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
         q_new = sum[WIDTH-1] ^ xop[WIDTH-1];
      end else begin
         b   = is_dec ? 16'hFFFF : 16'h0000;
         cin = ~is_dec;
         sum = {1'b0, yop} + {1'b0, b} + {{WIDTH{1'b0}}, cin};
      end
      res.value = sum[WIDTH-1:0];
      res.zero  = (sum[WIDTH-1:0] == '0);
      res.neg   = sum[WIDTH-1];
      res.ovf   = (yop[WIDTH-1] == b[WIDTH-1]) && (sum[WIDTH-1] != yop[WIDTH-1]);
      res.carry = sum[WIDTH];
      res.quot  = q_new;
   end
endmodule : alu_step
`default_nettype wire

// ===== test/seq_model.sv
// Instruction issuer standing in for the decoder and program sequencer
`timescale 1ns/1ps
`default_nettype none
`include "alu_defs.svh"

module seq_model #(
   parameter logic [3:0] COND_ALWAYS = 4'hF
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   output logic             instr_valid,
   output logic [23:0]      instr,
   output logic             cond_true,
   output logic [15:0]      mac_result_hi,
   output logic [15:0]      mac_result_mid,
   output logic [15:0]      mac_result_lo,
   output logic [15:0]      shift_result_hi,
   output logic [15:0]      shift_result_lo
);
   // ====================
   // Encoders: the condition field is informative, its verdict rides on cond_true
   logic [24:0] pend[$];
   int          gap = 0;
   int          gap_cnt = 0;

   function automatic logic [23:0] incdec(input logic dest, dec, input logic [1:0] ys, input logic [2:0] xs);
      return {`OPC_TYPE9, dest, dec ? `FC_DEC : `FC_INC, ys, xs, 4'h0, COND_ALWAYS};
   endfunction : incdec
   function automatic logic [23:0] div_quotient_step(input logic [2:0] xs);
      return {`OPC_DIV_QUOTIENT_STEP, xs, 8'h00};
   endfunction : div_quotient_step
   function automatic logic [23:0] div_sign_step(input logic [1:0] ys, input logic [2:0] xs);
      return {`OPC_DIV_SIGN_STEP, ys, xs, 8'h00};
   endfunction : div_sign_step
   task automatic push(input logic [23:0] w, input logic c);
      pend.push_back({c, w});
   endtask : push

   initial begin
      instr_valid = 1'b0;
      instr = 24'h000000;
      cond_true = 1'b1;
      mac_result_hi = 16'hA001;
      mac_result_mid = 16'hA002;
      mac_result_lo = 16'hA003;
      shift_result_hi = 16'hA004;
      shift_result_lo = 16'hA005;
   end
   // ====================
   // Issue one word per edge, or spaced by gap; idle lines toggle so nothing stale looks valid
   always @(posedge aclk) begin
      if (!aresetn) begin
         instr_valid <= 1'b0;
         gap_cnt <= 0;
      end else if (gap_cnt != 0 || pend.size() == 0) begin
         instr_valid <= 1'b0;
         instr <= ~instr;
         cond_true <= ~cond_true;
         if (gap_cnt != 0) gap_cnt <= gap_cnt - 1;
      end else begin
         {cond_true, instr} <= pend.pop_front();
         instr_valid <= 1'b1;
         gap_cnt <= gap;
      end
   end
endmodule : seq_model
`default_nettype wire

// ===== test/test_alu_incdec_divide_step.sv
// Self-checking bench for the increment, decrement and divide-step slice
`timescale 1ns/1ps
`default_nettype none

module test_alu_incdec_divide_step;
   localparam int ST = 0, Y0 = 1, Y1 = 2, X0 = 3, X1 = 4, RS = 5, FB = 6;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        instr_valid, cond_true, instr_done;
   logic [5:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [23:0] instr;
   logic [15:0] mac_result_hi, mac_result_mid, mac_result_lo, shift_result_hi, shift_result_lo;
   int          n_mismatch = 0;
   int          compares = 0;
   int          n_done = 0;

   alu_incdec_divide_step uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr_valid,
      .instr, .cond_true, .mac_result_hi, .mac_result_mid, .mac_result_lo, .shift_result_hi, .shift_result_lo,
      .instr_done);
   seq_model pm (.aclk, .aresetn, .instr_valid, .instr, .cond_true, .mac_result_hi, .mac_result_mid,
      .mac_result_lo, .shift_result_hi, .shift_result_lo);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) if (instr_done === 1'b1) n_done <= n_done + 1;

   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // ====================
   // Bus cycles; a lost answer is bounded so one hang does not hide the rest
   task automatic wr(input int k, input logic [15:0] v, input logic [1:0] er = 2'h0);
      int t;
      s_axi_awaddr <= 6'(4 * k);
      s_axi_wdata <= {16'h0000, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         t++;
      end while (s_axi_bvalid !== 1'b1 && t < 40);
      if (t >= 40) n_mismatch++;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask : wr
   task automatic rchk(input int k, input logic [15:0] e, input logic [1:0] er = 2'h0,
                       input logic [15:0] m = 16'hFFFF);
      int t;
      s_axi_araddr <= 6'(4 * k);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      t = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         t++;
      end while (s_axi_rvalid !== 1'b1 && t < 40);
      if (t >= 40) n_mismatch++;
      chk({30'h0, s_axi_rresp}, {30'h0, er});
      chk(s_axi_rdata & {16'h0000, m}, {16'h0000, e & m});
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask : rchk
   task automatic settle();
      int t;
      t = 0;
      while ((pm.pend.size() != 0 || instr_valid === 1'b1) && t < 200) begin
         @(posedge aclk);
         t++;
      end
      repeat (3) @(posedge aclk);
   endtask : settle
   function automatic logic [19:0] ref_incdec(input logic [15:0] y, input logic dec);
      logic [16:0] s;
      s = {1'b0, y} + (dec ? 17'h0FFFF : 17'h00001);
      return {s[16], (y[15] == dec) && (s[15] != y[15]), s[15], s[15:0] == 16'h0000, s[15:0]};
   endfunction : ref_incdec
   // ====================
   // Scenarios
   task automatic t_regs();
      for (int i = 0; i < 7; i++) rchk(i, 16'h0000);
      wr(Y0, 16'hFFFF);
      rchk(Y0, 16'hFFFF);
      wr(ST, 16'hFFFF);
      rchk(ST, 16'h00FF);
      rchk(7, 16'h0000, 2'h2);
      wr(8, 16'h1234, 2'h2);
   endtask : t_regs
   task automatic t_incdec(input logic dec, input logic [1:0] ys, input logic dest, input logic [15:0] y, c);
      logic [19:0] e;
      logic [15:0] fbv;
      int          n0;
      wr(Y0, 16'h1111);
      wr(Y1, 16'h2222);
      wr(FB, 16'h3333);
      wr(RS, 16'h5555);
      wr(ST, 16'h00F0);
      if (ys != 2'h3) wr(ys == 2'h2 ? FB : Y0 + int'(ys), y);
      e = ref_incdec(ys == 2'h3 ? 16'h0000 : y, dec);
      fbv = ys == 2'h2 ? y : 16'h3333;
      n0 = n_done;
      pm.push(pm.incdec(dest, dec, ys, {dec, ys}), c);
      settle();
      chk(32'(n_done - n0), {31'h0, c});
      rchk(dest ? RS : FB, dest ? 16'h5555 : fbv);
      rchk(dest ? FB : RS, c ? e[15:0] : (dest ? fbv : 16'h5555));
      rchk(ST, c ? {12'h00F, e[19:16]} : 16'h00F0);
   endtask : t_incdec
   task automatic t_b2b();
      int n0;
      wr(Y0, 16'h0010);
      wr(Y1, 16'h0020);
      n0 = n_done;
      pm.push(pm.incdec(1'b0, 1'b0, 2'h0, 3'h3), 1'b1);
      pm.push(pm.incdec(1'b1, 1'b1, 2'h1, 3'h6), 1'b1);
      settle();
      chk(32'(n_done - n0), 32'h2);
      rchk(RS, 16'h0011);
      rchk(FB, 16'h001F);
   endtask : t_b2b
   task automatic t_div(input logic sgn, input logic [15:0] up, lo, den, input logic [2:0] xs, input logic [15:0] q);
      int n0;
      wr(sgn ? Y1 : FB, up);
      wr(Y0, lo);
      wr(X1, den);
      pm.mac_result_lo <= den;
      pm.mac_result_mid <= den;
      wr(ST, 16'h00D0);
      pm.gap = sgn ? 2 : 0;
      n0 = n_done;
      if (sgn) pm.push(pm.div_sign_step(2'h1, xs), 1'b1);
      repeat (sgn ? 15 : 16) pm.push(pm.div_quotient_step(xs), 1'b1);
      settle();
      pm.gap = 0;
      chk(32'(n_done - n0), 32'h10);
      rchk(Y0, q);
      wr(ST, 16'h0000);
   endtask : t_div
   task automatic t_sign(input logic [1:0] ys, input logic [15:0] yv, xv, input logic aq);
      wr(ys == 2'h1 ? Y1 : FB, yv);
      wr(X0, xv);
      wr(ST, 16'h00D0);
      pm.push(pm.div_sign_step(ys, 3'h0), 1'b1);
      settle();
      // Zero, negative, overflow and carry are meaningless after a divide step
      rchk(ST, {8'h00, 4'hD | {2'b00, aq, 1'b0}, 4'h0}, 2'h0, 16'h00F0);
   endtask : t_sign

   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs();
      t_incdec(1'b0, 2'h0, 1'b0, 16'h7FFF, 1'b1);
      t_incdec(1'b0, 2'h1, 1'b1, 16'hFFFF, 1'b1);
      t_incdec(1'b1, 2'h2, 1'b0, 16'h8000, 1'b1);
      t_incdec(1'b1, 2'h0, 1'b1, 16'h0001, 1'b1);
      t_incdec(1'b0, 2'h3, 1'b1, 16'h0000, 1'b1);
      t_incdec(1'b1, 2'h3, 1'b0, 16'h0000, 1'b1);
      t_incdec(1'b0, 2'h2, 1'b1, 16'h1234, 1'b0);
      t_incdec(1'b1, 2'h1, 1'b0, 16'h1234, 1'b0);
      t_b2b();
      t_div(1'b0, 16'h0001, 16'h2345, 16'h0100, 3'h5, 16'h0123);
      t_div(1'b0, 16'h0FFE, 16'hFFFF, 16'h0FFF, 3'h4, 16'hFFFF);
      t_div(1'b1, 16'h0000, 16'h03E8, 16'h0007, 3'h1, 16'h008E);
      t_sign(2'h1, 16'h0001, 16'hFFF9, 1'b1);
      t_sign(2'h2, 16'h8000, 16'h0007, 1'b1);
      t_sign(2'h2, 16'h8000, 16'hFFF9, 1'b0);
      t_sign(2'h1, 16'h0001, 16'h0007, 1'b0);
      give_verdict();
   end
   initial begin
      #(20000 * 100);
      n_mismatch++;
      give_verdict();
   end
endmodule : test_alu_incdec_divide_step
`default_nettype wire
